//--- hw/sar_params.svh
// constants for the converter readout link
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH
`define SAR_WORD_BITS 18
`define SAR_MSB 17
`define SAR_CLK_PERIOD_NS 20
`define SAR_CONV_TIME_NS 1100
`define SAR_CNT_W 6
`define SAR_CONV_LAST (6'((`SAR_CONV_TIME_NS / `SAR_CLK_PERIOD_NS) - 1))
`define SAR_ABORT_CODE 18'h3fc00
`define SAR_RESULT_RST 18'h00000
`define SAR_BIT_W 5
`define SAR_LAST_SHIFT 5'h10
`define SAR_SCLK_MAX_KHZ 40000
`define SAR_SCLK_HALF_NS 160
`define SAR_SCLK_HALF (6'((`SAR_SCLK_HALF_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS - 1))
`define SAR_CTRL_CYCLES 6'h03
`define SAR_DEV_SYNC_RST 4'hf
`define SAR_I_CONV 3
`define SAR_I_CS 2
`define SAR_I_FS 1
`define SAR_I_SCLK 0
`define SAR_I_BUSY 1
`define SAR_I_SDO 0
`endif

//--- hw/sar_pkg.sv
// shared types for the converter readout link
`include "sar_params.svh"
package sar_pkg;
  typedef logic [`SAR_MSB:0] sar_word_t;
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT_GO, RD_WAIT_FALL, RD_SHIFT} sar_rd_state_t;
  typedef enum logic [3:0] {
    H_IDLE, H_SEL, H_CONV, H_BUSY_HI, H_BUSY_LO, H_FS_HI, H_SETUP, H_SCK_LO, H_SCK_HI
  } sar_host_state_t;
endpackage

//--- hw/sar_link_if.sv
// pin-level link between converter and host
`timescale 1ns/10ps
interface sar_link_if;
  logic conversion_start_n;
  logic cs_n;
  logic frame_sync_select;
  logic sclk;
  logic sdo;
  logic busy;
  modport dev (
    input conversion_start_n,
    input cs_n,
    input frame_sync_select,
    input sclk,
    output sdo,
    output busy
  );
  modport host (
    output conversion_start_n,
    output cs_n,
    output frame_sync_select,
    output sclk,
    input sdo,
    input busy
  );
endinterface

//--- hw/sar_pair_fifo.sv
// two-entry word buffer with valid/ready on both sides
`timescale 1ns/10ps
module sar_pair_fifo (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire sar_pkg::sar_word_t in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output sar_pkg::sar_word_t out_data_o
);
  import sar_pkg::*;
  sar_word_t mem_q [0:1];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule

//--- hw/sar_adc_dev.sv
// converter end: conversion timing and serial result readout
//
// Behaviour
// - host holds frame sync high in SPI mode
// - MSB appears when chip select falls
// - next bits on rising edges after first fall
// - chip select refall restarts frame from MSB
// - MSB appears on frame sync rising edge
// - frame sync mode shifts after fall then rise
// - frame sync high at busy fall reloads MSB
// - frame sync rise aborts frame, starts new
// - conversions started only by start and select
// - conversion timed by own internal clock
// - serial clock only shifts read data
// - conversion ends within 1.1 microseconds
// - serial clock at most 40 MHz
// - results are two's complement words
// - input captured at start, held throughout
// - host keeps signals quiet around start
// - start qualified by chip select low, falling
// - aborted conversion reads 0x3fc00
// - held result replaced when busy falls
// - 18-bit words, most significant first
`timescale 1ns/10ps
`include "sar_params.svh"
module sar_adc_dev (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  sar_link_if.dev link,
  input wire sar_pkg::sar_word_t sample_i,
  output sar_pkg::sar_word_t result_o,
  output logic conv_done_o,
  output logic busy_o
);
  import sar_pkg::*;

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur && !prev;
  endfunction

  function automatic logic fall(input logic cur, input logic prev);
    fall = !cur && prev;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge history
  logic [3:0] pins;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] pv_q;
  logic conv_s;
  logic cs_s;
  logic fs_s;
  logic sck_s;

  assign pins = {link.conversion_start_n, link.cs_n, link.frame_sync_select, link.sclk};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_q <= `SAR_DEV_SYNC_RST;
      s2_q <= `SAR_DEV_SYNC_RST;
      pv_q <= `SAR_DEV_SYNC_RST;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      pv_q <= s2_q;
    end
  end

  assign conv_s = s2_q[`SAR_I_CONV];
  assign cs_s = s2_q[`SAR_I_CS];
  assign fs_s = s2_q[`SAR_I_FS];
  assign sck_s = s2_q[`SAR_I_SCLK];

  ////////////////////////////////////////////////////////////////////////
  // qualified start: start level latched while select is low
  logic qualified_convert_start_q;
  logic qual_prev_q;
  logic start;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      qualified_convert_start_q <= 1'b1;
      qual_prev_q <= 1'b1;
    end else begin
      if (!cs_s) begin
        qualified_convert_start_q <= conv_s;
      end
      qual_prev_q <= qualified_convert_start_q;
    end
  end

  assign start = fall(qualified_convert_start_q, qual_prev_q);

  ////////////////////////////////////////////////////////////////////////
  // conversion timer on the own clock, never on the serial clock
  logic busy_q;
  logic [`SAR_CNT_W-1:0] cnt_q;
  logic conv_end;

  assign conv_end = busy_q && (cnt_q == `SAR_CONV_LAST);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else if (start && busy_q) begin
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
      cnt_q <= '0;
    end else if (conv_end) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // captured input and held result
  sar_word_t cap_q;
  sar_word_t result_q;
  logic done_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cap_q <= `SAR_RESULT_RST;
      result_q <= `SAR_RESULT_RST;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start && busy_q) begin
        result_q <= `SAR_ABORT_CODE;
      end else if (start) begin
        cap_q <= sample_i;
      end else if (conv_end) begin
        result_q <= cap_q;
        done_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read frame: load, wait for first fall, shift on rises
  sar_rd_state_t rd_q;
  sar_word_t sh_q;
  logic [`SAR_BIT_W-1:0] bits_q;
  logic cs_fall;
  logic fs_rise;
  logic fs_fall;
  logic sck_rise;
  logic sck_fall;

  assign cs_fall = fall(cs_s, pv_q[`SAR_I_CS]);
  assign fs_rise = rise(fs_s, pv_q[`SAR_I_FS]);
  assign fs_fall = fall(fs_s, pv_q[`SAR_I_FS]);
  assign sck_rise = rise(sck_s, pv_q[`SAR_I_SCLK]);
  assign sck_fall = fall(sck_s, pv_q[`SAR_I_SCLK]);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_q <= RD_IDLE;
      sh_q <= `SAR_RESULT_RST;
      bits_q <= '0;
    end else if (fs_s && cs_fall) begin
      sh_q <= result_q;
      bits_q <= '0;
      rd_q <= RD_WAIT_FALL;
    end else if (fs_rise) begin
      sh_q <= result_q;
      bits_q <= '0;
      rd_q <= RD_WAIT_GO;
    end else if (conv_end && fs_s && rd_q != RD_SHIFT) begin
      sh_q <= cap_q;
    end else begin
      case (rd_q)
        RD_WAIT_GO: begin
          if (fs_fall) begin
            rd_q <= RD_WAIT_FALL;
          end
        end
        RD_WAIT_FALL: begin
          if (sck_fall) begin
            rd_q <= RD_SHIFT;
          end
        end
        RD_SHIFT: begin
          if (sck_rise) begin
            sh_q <= {sh_q[`SAR_MSB-1:0], 1'b0};
            bits_q <= bits_q + 1'b1;
            if (bits_q == `SAR_LAST_SHIFT) begin
              rd_q <= RD_IDLE;
            end
          end
        end
        default: begin
          rd_q <= RD_IDLE;
        end
      endcase
    end
  end

  assign link.sdo = sh_q[`SAR_MSB];
  assign link.busy = busy_q;
  assign busy_o = busy_q;
  assign result_o = result_q;
  assign conv_done_o = done_q;
endmodule

//--- hw/sar_adc_host.sv
// host end: starts conversions, reads words, buffers them
`timescale 1ns/10ps
`include "sar_params.svh"
module sar_adc_host (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  sar_link_if.host link,
  input wire logic start_i,
  input wire logic fs_mode_i,
  output logic start_ready_o,
  output sar_pkg::sar_word_t word_o,
  output logic word_valid_o,
  input wire logic word_ready_i
);
  import sar_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // busy and data synchronisers
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic busy_s;
  logic sdo_s;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
    end else begin
      s1_q <= {link.busy, link.sdo};
      s2_q <= s1_q;
    end
  end

  assign busy_s = s2_q[`SAR_I_BUSY];
  assign sdo_s = s2_q[`SAR_I_SDO];

  ////////////////////////////////////////////////////////////////////////
  // control sequencer
  sar_host_state_t st_q;
  logic [`SAR_CNT_W-1:0] tmr_q;
  logic [`SAR_BIT_W-1:0] nb_q;
  logic mode_q;
  logic cs_q;
  logic conv_q;
  logic fs_q;
  logic sck_q;
  logic push_q;
  sar_word_t w_q;
  logic buf_ready;
  logic tmr_done;

  assign tmr_done = (tmr_q == '0);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_q <= H_IDLE;
      tmr_q <= '0;
      nb_q <= '0;
      mode_q <= 1'b0;
      cs_q <= 1'b1;
      conv_q <= 1'b1;
      fs_q <= 1'b1;
      sck_q <= 1'b1;
      push_q <= 1'b0;
      w_q <= `SAR_RESULT_RST;
    end else begin
      push_q <= 1'b0;
      if (!tmr_done) begin
        tmr_q <= tmr_q - 1'b1;
      end
      case (st_q)
        H_IDLE: begin
          fs_q <= !fs_mode_i;
          mode_q <= fs_mode_i;
          if (start_i && buf_ready) begin
            cs_q <= 1'b0;
            tmr_q <= `SAR_CTRL_CYCLES;
            st_q <= H_SEL;
          end
        end
        H_SEL: begin
          if (tmr_done) begin
            conv_q <= 1'b0;
            tmr_q <= `SAR_CTRL_CYCLES;
            st_q <= H_CONV;
          end
        end
        H_CONV: begin
          if (tmr_done) begin
            conv_q <= 1'b1;
            cs_q <= 1'b1;
            st_q <= H_BUSY_HI;
          end
        end
        H_BUSY_HI: begin
          if (busy_s) begin
            st_q <= H_BUSY_LO;
          end
        end
        H_BUSY_LO: begin
          if (!busy_s) begin
            cs_q <= 1'b0;
            fs_q <= 1'b1;
            // spi: loaded msb must pass the device syncs and ours first
            tmr_q <= mode_q ? `SAR_CTRL_CYCLES : `SAR_SCLK_HALF;
            st_q <= mode_q ? H_FS_HI : H_SETUP;
          end
        end
        H_FS_HI: begin
          if (tmr_done) begin
            fs_q <= 1'b0;
            tmr_q <= `SAR_SCLK_HALF;
            st_q <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (tmr_done) begin
            sck_q <= 1'b0;
            w_q <= {w_q[`SAR_MSB-1:0], sdo_s};
            nb_q <= 5'h01;
            tmr_q <= `SAR_SCLK_HALF;
            st_q <= H_SCK_LO;
          end
        end
        H_SCK_LO: begin
          if (tmr_done) begin
            sck_q <= 1'b1;
            tmr_q <= `SAR_SCLK_HALF;
            st_q <= H_SCK_HI;
          end
        end
        H_SCK_HI: begin
          if (tmr_done && nb_q == 5'(`SAR_WORD_BITS)) begin
            cs_q <= 1'b1;
            fs_q <= !mode_q;
            push_q <= 1'b1;
            st_q <= H_IDLE;
          end else if (tmr_done) begin
            sck_q <= 1'b0;
            w_q <= {w_q[`SAR_MSB-1:0], sdo_s};
            nb_q <= nb_q + 1'b1;
            tmr_q <= `SAR_SCLK_HALF;
            st_q <= H_SCK_LO;
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  assign link.cs_n = cs_q;
  assign link.conversion_start_n = conv_q;
  assign link.frame_sync_select = fs_q;
  assign link.sclk = sck_q;
  assign start_ready_o = (st_q == H_IDLE) && buf_ready;

  ////////////////////////////////////////////////////////////////////////
  // received words wait here until the user takes them
  sar_pair_fifo u_buf (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(push_q),
    .in_ready_o(buf_ready),
    .in_data_i(w_q),
    .out_valid_o(word_valid_o),
    .out_ready_i(word_ready_i),
    .out_data_o(word_o)
  );
endmodule

//--- testbench/sar_link_sva.sv
// link checks between converter end and host end
`timescale 1ns/10ps
module sar_link_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic conversion_start_n,
  input wire logic cs_n,
  input wire logic frame_sync_select,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic busy
);
  logic [6:0] busy_cnt_q;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // busy length counter
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !busy) begin
      busy_cnt_q <= 7'h00;
    end else begin
      busy_cnt_q <= busy_cnt_q + 7'h01;
    end
  end
  ////////////////////////////////////////////////////////////////
  AST_BUSY_RISE: assert property (
    $fell(conversion_start_n) && !cs_n && !busy |-> ##4 busy) else $error("busy late after start");
  AST_START_QUAL: assert property (
    $rose(busy) |-> !$past(conversion_start_n, 4) && $past(conversion_start_n, 5) && !$past(cs_n, 4))
    else $error("busy without qualified start");
  AST_CONV_TIME: assert property (
    $fell(busy) |-> busy_cnt_q == 7'd55) else $error("conversion length wrong");
  AST_CONV_MAX: assert property (
    busy |-> busy_cnt_q < 7'd55) else $error("conversion too long");
  AST_SDO_CAUSE: assert property (
    $changed(sdo) && !$fell(busy) |-> ($past(sclk, 3) && !$past(sclk, 4))
      || (!$past(cs_n, 3) && $past(cs_n, 4)) || ($past(frame_sync_select, 3) && !$past(frame_sync_select, 4)))
    else $error("data moved without cause");
  AST_SCLK_IDLE: assert property (
    cs_n |-> sclk) else $error("serial clock low outside frame");
  AST_SCLK_LOW: assert property (
    $fell(sclk) |-> (!sclk)[*8] ##1 sclk) else $error("serial clock low phase wrong");
  AST_CONV_CS: assert property (
    !conversion_start_n |-> !cs_n) else $error("start without select");
  AST_START_QUIET: assert property (
    $fell(conversion_start_n) |-> sclk && $stable(frame_sync_select) && $stable(cs_n))
    else $error("noise around start");
  COV_CONV_END: cover property ($fell(busy));
  COV_CS_FRAME: cover property ($fell(cs_n) && frame_sync_select);
  COV_FS_FRAME: cover property ($fell(frame_sync_select) && !cs_n);
endmodule

//--- testbench/sar_adc_serial_readout_test.sv
// self-checking bench for the converter readout link
`timescale 1ns/10ps
module sar_adc_serial_readout_test;
  import sar_pkg::*;
  typedef struct {logic fs; sar_word_t smp; sar_word_t exp;} sar_row_t;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic fs_mode_i = 1'b0;
  logic word_ready_i = 1'b0;
  sar_word_t sample_i = 18'h00000;
  logic start_ready_o;
  logic word_valid_o;
  logic conv_done_o;
  logic busy_o;
  sar_word_t word_o;
  sar_word_t result_o;
  int err_total = 0;
  int cmp_count = 0;
  sar_row_t rows [8];
  sar_link_if link ();
  always #10 ref_clk_i = ~ref_clk_i;
  sar_adc_dev sar_adc_dev_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link.dev), .sample_i(sample_i),
    .result_o(result_o), .conv_done_o(conv_done_o), .busy_o(busy_o));
  sar_adc_host sar_adc_host_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link.host), .start_i(start_i),
    .fs_mode_i(fs_mode_i), .start_ready_o(start_ready_o), .word_o(word_o), .word_valid_o(word_valid_o),
    .word_ready_i(word_ready_i));
  sar_link_sva sar_link_sva_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .conversion_start_n(link.conversion_start_n), .cs_n(link.cs_n), .frame_sync_select(link.frame_sync_select),
    .sclk(link.sclk), .sdo(link.sdo), .busy(link.busy));
  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp_word(input sar_word_t got, input sar_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t flag %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_on(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 2000) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 2000) begin
      err_total++;
      $display("[ERR] %0t wait ran out got %h exp %h", $time, s, v);
      finish_test();
    end
  endtask
  // start one conversion, then disturb the input it captured
  task automatic convert(input logic fs, input sar_word_t smp);
    sample_i = smp;
    fs_mode_i = fs;
    wait_on(start_ready_o, 1'b1);
    start_i = 1'b1;
    @(negedge ref_clk_i);
    start_i = 1'b0;
    wait_on(busy_o, 1'b1);
    sample_i = ~smp;
  endtask
  task automatic pop(input sar_word_t exp);
    wait_on(word_valid_o, 1'b1);
    cmp_word(word_o, exp);
    word_ready_i = 1'b1;
    @(negedge ref_clk_i);
    word_ready_i = 1'b0;
  endtask
  task automatic reset_checks();
    cmp_bit(busy_o, 1'b0);
    cmp_bit(word_valid_o, 1'b0);
    cmp_bit(link.cs_n, 1'b1);
    cmp_bit(link.sclk, 1'b1);
    cmp_bit(link.frame_sync_select, 1'b1);
    cmp_word(result_o, 18'h00000);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{1'b0, 18'h1ffff, 18'h1ffff}, '{1'b0, 18'h00000, 18'h00000}, '{1'b0, 18'h3ffff, 18'h3ffff},
      '{1'b0, 18'h20000, 18'h20000}, '{1'b1, 18'h1ffff, 18'h1ffff}, '{1'b1, 18'h00000, 18'h00000},
      '{1'b1, 18'h3ffff, 18'h3ffff}, '{1'b1, 18'h20000, 18'h20000}};
    repeat (5) @(negedge ref_clk_i);
    reset_checks();
    rst_i = 1'b0;
    $display("test reset done");
    foreach (rows[i]) begin
      convert(rows[i].fs, rows[i].smp);
      wait_on(conv_done_o, 1'b1);
      cmp_word(result_o, rows[i].exp);
      @(negedge ref_clk_i);
      cmp_bit(conv_done_o, 1'b0);
      pop(rows[i].exp);
    end
    $display("test table done");
    // buffer fills, host stalls, then drains in order
    convert(1'b0, 18'h0f0f0);
    convert(1'b1, 18'h30303);
    wait_on(start_ready_o, 1'b0);
    // long enough for the second frame to finish and fill the buffer
    repeat (600) @(negedge ref_clk_i);
    cmp_bit(start_ready_o, 1'b0);
    cmp_bit(busy_o, 1'b0);
    cmp_bit(link.cs_n, 1'b1);
    pop(18'h0f0f0);
    pop(18'h30303);
    cmp_bit(word_valid_o, 1'b0);
    $display("test buffer done");
    // reset in mid conversion, then recover
    convert(1'b0, 18'h12345);
    repeat (20) @(negedge ref_clk_i);
    rst_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    reset_checks();
    rst_i = 1'b0;
    convert(1'b0, 18'h2a5a5);
    pop(18'h2a5a5);
    $display("test midrun reset done");
    finish_test();
  end
endmodule
